// >>> logic/atp_pkg.sv
package atp_pkg;

	// register addresses (7-bit serial address field)
	localparam logic [6:0] ADDR_SOFT_RESET   = 7'h00;
	localparam logic [6:0] ADDR_FORMAT       = 7'h01;
	localparam logic [6:0] ADDR_OUTPUT_MODE  = 7'h02;
	localparam logic [6:0] ADDR_PATTERN_HIGH = 7'h03;
	localparam logic [6:0] ADDR_PATTERN_LOW  = 7'h04;

	// all mode control registers come out of either reset as zero
	localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
	localparam logic [7:0] UNMAPPED_READ     = 8'h00;

	// field positions
	localparam int SOFT_RESET_BIT    = 7;
	localparam int FORCE_ENABLE_BIT  = 7;
	localparam int IGNORED_BIT       = 6;
	localparam int HIGH_BITS_MSB     = 5;
	localparam int LOW_BITS_MSB      = 7;
	localparam int PAD_FIRST_BIT     = 1;
	localparam int PAD_SECOND_BIT    = 0;

	// serial word layout
	localparam logic [4:0] HEADER_EDGES = 5'h08;
	localparam logic [4:0] WORD_EDGES   = 5'h10;

	// widths
	localparam int SAMPLE_WIDTH = 12;
	localparam int WORD_WIDTH   = 14;

	typedef enum logic [1:0] {
		RX_IDLE   = 2'b00,
		RX_HEADER = 2'b01,
		RX_DATA   = 2'b11,
		RX_DONE   = 2'b10
	} atp_rx_state_type;

	typedef struct packed {
		logic       read_flag;
		logic [6:0] addr;
		logic [7:0] data;
	} atp_cmd_type;

endpackage : atp_pkg

// >>> logic/atp_spi_rx.sv
`timescale 1ns/1ns
module atp_spi_rx (
	// clock, reset, enable
	input  wire logic                  ref_clk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	// serial pins, sampled as synchronous inputs
	input  wire logic                  cs_n,
	input  wire logic                  sck,
	input  wire logic                  sdi,
	// decoded command
	output atp_pkg::atp_cmd_type       cmd_q,
	output logic                       header_done_q,
	output logic                       word_done_q,
	output logic                       shift_out_q,
	output logic                       frame_active_q
);

	atp_pkg::atp_rx_state_type state_q;
	logic [4:0]                edge_cnt_q;
	logic [14:0]               shift_q;
	logic                      sck_prev_q;
	logic                      rise;
	logic                      fall;

	assign rise = !cs_n && sck && !sck_prev_q;
	assign fall = !cs_n && !sck && sck_prev_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sck_prev_q <= 1'b0;
		end else if (ce) begin
			sck_prev_q <= sck;
		end
	end

	// edge counter and state; anything past the sixteenth edge is dropped
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q    <= atp_pkg::RX_IDLE;
			edge_cnt_q <= 5'h00;
		end else if (ce) begin
			if (cs_n) begin
				state_q    <= atp_pkg::RX_IDLE;
				edge_cnt_q <= 5'h00;
			end else begin
				unique case (state_q)
					atp_pkg::RX_IDLE: begin
						state_q <= atp_pkg::RX_HEADER;
					end
					atp_pkg::RX_HEADER: begin
						if (rise) begin
							edge_cnt_q <= edge_cnt_q + 5'h01;
							if (edge_cnt_q + 5'h01 == atp_pkg::HEADER_EDGES) begin
								state_q <= atp_pkg::RX_DATA;
							end
						end
					end
					atp_pkg::RX_DATA: begin
						if (rise) begin
							edge_cnt_q <= edge_cnt_q + 5'h01;
							if (edge_cnt_q + 5'h01 == atp_pkg::WORD_EDGES) begin
								state_q <= atp_pkg::RX_DONE;
							end
						end
					end
					atp_pkg::RX_DONE: begin
						state_q <= atp_pkg::RX_DONE;
					end
				endcase
			end
		end
	end

	// read flag first, then address, then data, msb first
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shift_q       <= 15'h0000;
			cmd_q         <= '0;
			header_done_q <= 1'b0;
			word_done_q   <= 1'b0;
		end else if (ce) begin
			header_done_q <= 1'b0;
			word_done_q   <= 1'b0;
			if (rise && (state_q == atp_pkg::RX_HEADER || state_q == atp_pkg::RX_DATA)) begin
				shift_q <= {shift_q[13:0], sdi};
				if (edge_cnt_q + 5'h01 == atp_pkg::HEADER_EDGES) begin
					cmd_q.read_flag <= shift_q[6];
					cmd_q.addr      <= {shift_q[5:0], sdi};
					header_done_q   <= 1'b1;
				end
				if (edge_cnt_q + 5'h01 == atp_pkg::WORD_EDGES) begin
					cmd_q.data  <= {shift_q[6:0], sdi};
					word_done_q <= 1'b1;
				end
			end
		end
	end

	// readback advances on falling edges during the data phase only
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shift_out_q    <= 1'b0;
			frame_active_q <= 1'b0;
		end else if (ce) begin
			shift_out_q    <= fall && (state_q == atp_pkg::RX_DATA);
			frame_active_q <= !cs_n;
		end
	end

endmodule : atp_spi_rx

// >>> logic/atp_regs.sv
`timescale 1ns/1ns
// Behaviour
// - register 03h bit 7 forces the programmed pattern onto the outputs
// - register 03h bit 6 is ignored and has no effect
// - register 03h bits 5..0 are pattern data bits 11 down to 6
// - register 04h bits 7..2 are pattern data bits 5 down to 0
// - register 04h bits 1..0 are the two extra pad bit patterns
// - one 16-bit word per access: read flag, address, data; extra edges ignored
// - reads return the register on the serial output and change nothing
// - software reset clears every mode control register to zero
module atp_regs (
	// clock, reset, enable
	input  wire logic                                   ref_clk,
	input  wire logic                                   srst,
	input  wire logic                                   ce,
	// serial configuration port
	input  wire logic                                   cs_n,
	input  wire logic                                   sck,
	input  wire logic                                   sdi,
	output logic                                        sdo_level,
	output logic                                        sdo_oe,
	// conversion results in
	input  wire logic [atp_pkg::SAMPLE_WIDTH-1:0]       sample_a,
	input  wire logic [atp_pkg::SAMPLE_WIDTH-1:0]       sample_b,
	// words toward the serializer
	output logic [atp_pkg::WORD_WIDTH-1:0]              out_word_a_q,
	output logic [atp_pkg::WORD_WIDTH-1:0]              out_word_b_q,
	// mode settings for neighbouring blocks
	output logic                                        pattern_force_enable,
	output logic [7:0]                                  format_q,
	output logic [7:0]                                  output_mode_q,
	output logic [7:0]                                  test_pattern_high_q,
	output logic [7:0]                                  test_pattern_low_q
);

	atp_pkg::atp_cmd_type cmd;
	logic                 header_done;
	logic                 word_done;
	logic                 shift_out;
	logic                 frame_active;
	logic [7:0]           rd_shift_q;
	logic [7:0]           rd_shift_d;
	logic                 rd_active_q;
	logic                 rd_active_d;
	logic [7:0]           read_value;
	logic [5:0]           pattern_high_bits;
	logic [5:0]           pattern_low_bits;
	logic                 pad_bit_first;
	logic                 pad_bit_second;
	logic [atp_pkg::WORD_WIDTH-1:0] pattern_word;

	atp_spi_rx u_rx (
		.ref_clk        (ref_clk),
		.srst           (srst),
		.ce             (ce),
		.cs_n           (cs_n),
		.sck            (sck),
		.sdi            (sdi),
		.cmd_q          (cmd),
		.header_done_q  (header_done),
		.word_done_q    (word_done),
		.shift_out_q    (shift_out),
		.frame_active_q (frame_active)
	);

	// register writes land when the sixteenth edge completes the word
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			format_q            <= atp_pkg::REG_RESET_VALUE;
			output_mode_q       <= atp_pkg::REG_RESET_VALUE;
			test_pattern_high_q <= atp_pkg::REG_RESET_VALUE;
			test_pattern_low_q  <= atp_pkg::REG_RESET_VALUE;
		end else if (ce && word_done && !cmd.read_flag) begin
			unique case (cmd.addr)
				atp_pkg::ADDR_SOFT_RESET: begin
					// the reset bit itself is never stored, so it reads back as zero
					if (cmd.data[atp_pkg::SOFT_RESET_BIT]) begin
						format_q            <= atp_pkg::REG_RESET_VALUE;
						output_mode_q       <= atp_pkg::REG_RESET_VALUE;
						test_pattern_high_q <= atp_pkg::REG_RESET_VALUE;
						test_pattern_low_q  <= atp_pkg::REG_RESET_VALUE;
					end
				end
				atp_pkg::ADDR_FORMAT: begin
					format_q <= cmd.data;
				end
				atp_pkg::ADDR_OUTPUT_MODE: begin
					output_mode_q <= cmd.data;
				end
				atp_pkg::ADDR_PATTERN_HIGH: begin
					test_pattern_high_q <= cmd.data;
				end
				atp_pkg::ADDR_PATTERN_LOW: begin
					test_pattern_low_q <= cmd.data;
				end
				default: begin
					// unmapped addresses are silently dropped
				end
			endcase
		end
	end

	// bit 6 is kept for readback but nothing downstream looks at it
	assign pattern_high_bits = test_pattern_high_q[atp_pkg::HIGH_BITS_MSB -: 6];
	assign pattern_low_bits  = test_pattern_low_q[atp_pkg::LOW_BITS_MSB -: 6];
	assign pad_bit_first     = test_pattern_low_q[atp_pkg::PAD_FIRST_BIT];
	assign pad_bit_second    = test_pattern_low_q[atp_pkg::PAD_SECOND_BIT];
	assign pattern_word      = {pattern_high_bits, pattern_low_bits, pad_bit_first,
		pad_bit_second};
	assign pattern_force_enable = test_pattern_high_q[atp_pkg::FORCE_ENABLE_BIT];

	// sample path: data bits 11..0 then the two pad positions
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			out_word_a_q <= '0;
			out_word_b_q <= '0;
		end else if (ce) begin
			if (pattern_force_enable) begin
				out_word_a_q <= pattern_word;
				out_word_b_q <= pattern_word;
			end else begin
				out_word_a_q <= {sample_a, 2'b00};
				out_word_b_q <= {sample_b, 2'b00};
			end
		end
	end

	// readback source; the reset register is write only
	always_comb begin
		unique case (cmd.addr)
			atp_pkg::ADDR_FORMAT:       read_value = format_q;
			atp_pkg::ADDR_OUTPUT_MODE:  read_value = output_mode_q;
			atp_pkg::ADDR_PATTERN_HIGH: read_value = test_pattern_high_q;
			atp_pkg::ADDR_PATTERN_LOW:  read_value = test_pattern_low_q;
			default:                    read_value = atp_pkg::UNMAPPED_READ;
		endcase
	end

	always_comb begin
		rd_shift_d  = rd_shift_q;
		rd_active_d = rd_active_q;
		if (!frame_active) begin
			rd_active_d = 1'b0;
		end else if (header_done) begin
			rd_active_d = cmd.read_flag;
			rd_shift_d  = read_value;
		end else if (shift_out && rd_active_q) begin
			rd_shift_d = {rd_shift_q[6:0], 1'b0};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_shift_q  <= 8'h00;
			rd_active_q <= 1'b0;
		end else if (ce) begin
			rd_shift_q  <= rd_shift_d;
			rd_active_q <= rd_active_d;
		end
	end

	// open drain: only ever pull low, so the pad stays released for a one
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sdo_level <= 1'b0;
			sdo_oe    <= 1'b0;
		end else if (ce) begin
			sdo_level <= 1'b0;
			sdo_oe    <= rd_active_d && !rd_shift_d[7];
		end
	end

endmodule : atp_regs

// >>> testbench/atp_regs_sva.sv
`timescale 1ns/1ns
module atp_regs_sva (
	// clock and controls
	input  wire logic                             ref_clk,
	input  wire logic                             srst,
	input  wire logic                             ce,
	input  wire logic                             cs_n,
	// serial output
	input  wire logic                             sdo_level,
	input  wire logic                             sdo_oe,
	// data path
	input  wire logic [atp_pkg::SAMPLE_WIDTH-1:0] sample_a,
	input  wire logic [atp_pkg::SAMPLE_WIDTH-1:0] sample_b,
	input  wire logic [atp_pkg::WORD_WIDTH-1:0]   out_word_a_q,
	input  wire logic [atp_pkg::WORD_WIDTH-1:0]   out_word_b_q,
	// registers
	input  wire logic                             pattern_force_enable,
	input  wire logic [7:0]                       test_pattern_high_q,
	input  wire logic [7:0]                       test_pattern_low_q
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence s_idle;
		cs_n [*4];
	endsequence
	sequence s_forced;
		ce && pattern_force_enable;
	endsequence
	AST_FORCE_IN_FRAME: assert property ($rose(pattern_force_enable) |-> !cs_n)
		else $error("force switched on outside a write frame");
	AST_PATTERN_A: assert property (s_forced |=>
		out_word_a_q == {$past(test_pattern_high_q[5:0]), $past(test_pattern_low_q)})
		else $error("channel a pattern wrong");
	AST_PATTERN_B: assert property (s_forced |=>
		out_word_b_q == {$past(test_pattern_high_q[5:0]), $past(test_pattern_low_q)})
		else $error("channel b pattern wrong");
	AST_SAMPLE_A: assert property (ce && !pattern_force_enable |=>
		out_word_a_q == {$past(sample_a), 2'b00}) else $error("channel a sample wrong");
	AST_SAMPLE_B: assert property (ce && !pattern_force_enable |=>
		out_word_b_q == {$past(sample_b), 2'b00}) else $error("channel b sample wrong");
	AST_NO_WRITE_IDLE: assert property (s_idle |=>
		$stable(test_pattern_high_q) && $stable(test_pattern_low_q)) else $error("write while idle");
	AST_SDO_RELEASE: assert property (s_idle |-> !sdo_oe) else $error("sdo held");
	AST_SDO_LOW: assert property (sdo_oe |-> !sdo_level && !$past(cs_n, 2))
		else $error("sdo pulled outside a frame");
	AST_RESET_CLEAR: assert property (disable iff (1'b0) srst && ce |=>
		test_pattern_high_q == 8'h00 && test_pattern_low_q == 8'h00 && !sdo_oe)
		else $error("reset left state");
endmodule : atp_regs_sva
bind atp_regs atp_regs_sva atp_regs_sva_inst (.ref_clk, .srst, .ce, .cs_n, .sdo_level, .sdo_oe,
	.sample_a, .sample_b, .out_word_a_q, .out_word_b_q, .pattern_force_enable,
	.test_pattern_high_q, .test_pattern_low_q);

// >>> testbench/atp_host_model.sv
`timescale 1ns/1ns
module atp_host_model (
	// clock
	input  wire logic ref_clk,
	// serial port toward the device
	output logic      cs_n,
	output logic      sck,
	output logic      sdi,
	input  wire logic sdo_level,
	input  wire logic sdo_oe
);
	// open drain with pull-up: a released line reads 1
	wire sdo_line = sdo_oe ? sdo_level : 1'b1;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end
	// each sck level lasts 6 clocks so the device sees every edge
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] r);
		r = 8'h00;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		for (int k = 0; k < n; k++) begin
			sdi <= (k < 16) ? w[15 - k] : ~w[0];
			repeat (6) @(posedge ref_clk);
			sck <= 1'b1;
			repeat (6) @(posedge ref_clk);
			if (k >= 7 && k <= 14)
				r[14 - k] = sdo_line;
			sck <= 1'b0;
		end
		repeat (6) @(posedge ref_clk);
		cs_n <= 1'b1;
		sdi <= ~sdi;
		repeat (4) @(posedge ref_clk);
	endtask : xfer
endmodule : atp_host_model

// >>> testbench/tb_atp_regs.sv
`timescale 1ns/1ns
module tb_atp_regs;
	logic        ref_clk, srst, ce, cs_n, sck, sdi, sdo_level, sdo_oe, pattern_force_enable;
	logic [11:0] sample_a, sample_b;
	logic [13:0] out_word_a_q, out_word_b_q;
	logic [7:0]  test_pattern_high_q, test_pattern_low_q, format_q, output_mode_q;
	int          n_mismatch = 0;
	int          num_checks = 0;
	atp_regs atp_regs_inst (.ref_clk, .srst, .ce, .cs_n, .sck, .sdi, .sdo_level, .sdo_oe,
		.sample_a, .sample_b, .out_word_a_q, .out_word_b_q, .pattern_force_enable,
		.format_q, .output_mode_q, .test_pattern_high_q, .test_pattern_low_q);
	atp_host_model atp_host_model_inst (.ref_clk, .cs_n, .sck, .sdi, .sdo_level, .sdo_oe);
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		atp_host_model_inst.xfer({1'b0, a, d}, 16, r);
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] r);
		atp_host_model_inst.xfer({1'b1, a, 8'hff}, 16, r);
	endtask : rd
	task automatic t_soft_reset();
		logic [7:0] r;
		wr(atp_pkg::ADDR_SOFT_RESET, 8'h80);
		wr(atp_pkg::ADDR_PATTERN_LOW, 8'h3c);
		wr(atp_pkg::ADDR_PATTERN_HIGH, 8'h15);
		wr(atp_pkg::ADDR_FORMAT, 8'h21);
		wr(atp_pkg::ADDR_OUTPUT_MODE, 8'h05);
		chk("low written", {8'h00, test_pattern_low_q}, 16'h003c);
		chk("mode written", {8'h00, output_mode_q}, 16'h0005);
		rd(atp_pkg::ADDR_FORMAT, r);
		chk("format readback", {8'h00, r}, 16'h0021);
		wr(atp_pkg::ADDR_SOFT_RESET, 8'h80);
		rd(atp_pkg::ADDR_PATTERN_LOW, r);
		chk("low after soft reset", {8'h00, r}, 16'h0000);
		chk("high after soft reset", {8'h00, test_pattern_high_q}, 16'h0000);
		chk("format after soft reset", {8'h00, format_q}, 16'h0000);
		chk("mode after soft reset", {8'h00, output_mode_q}, 16'h0000);
		rd(atp_pkg::ADDR_SOFT_RESET, r);
		chk("reset reg read", {8'h00, r}, 16'h0000);
	endtask : t_soft_reset
	task automatic t_readback();
		logic [7:0] r;
		wr(atp_pkg::ADDR_PATTERN_HIGH, 8'h7f);
		rd(atp_pkg::ADDR_PATTERN_HIGH, r);
		chk("high readback", {8'h00, r & 8'hbf}, 16'h003f);
		chk("force off", {15'h0000, pattern_force_enable}, 16'h0000);
		chk("sample a", {2'b00, out_word_a_q}, {2'b00, sample_a, 2'b00});
		wr(atp_pkg::ADDR_PATTERN_LOW, 8'ha5);
		rd(atp_pkg::ADDR_PATTERN_LOW, r);
		chk("low readback", {8'h00, r}, 16'h00a5);
		rd(atp_pkg::ADDR_PATTERN_LOW, r);
		chk("low after read", {8'h00, r}, 16'h00a5);
		rd(7'h05, r);
		chk("unmapped read", {8'h00, r}, 16'h0000);
	endtask : t_readback
	task automatic t_force();
		wr(atp_pkg::ADDR_PATTERN_HIGH, 8'hea);
		chk("force on", {15'h0000, pattern_force_enable}, 16'h0001);
		chk("pattern a", {2'b00, out_word_a_q}, 16'h2aa5);
		chk("pattern b", {2'b00, out_word_b_q}, 16'h2aa5);
		wr(atp_pkg::ADDR_PATTERN_HIGH, 8'haa);
		chk("ignored bit", {2'b00, out_word_a_q}, 16'h2aa5);
		wr(atp_pkg::ADDR_PATTERN_HIGH, 8'h00);
		chk("sample b back", {2'b00, out_word_b_q}, {2'b00, sample_b, 2'b00});
	endtask : t_force
	task automatic t_freeze();
		@(posedge ref_clk);
		ce <= 1'b0;
		sample_a <= 12'h3a7;
		repeat (3) @(posedge ref_clk);
		chk("frozen word", {2'b00, out_word_a_q}, {2'b00, 12'h5c3, 2'b00});
		ce <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk("new sample", {2'b00, out_word_a_q}, {2'b00, 12'h3a7, 2'b00});
		sample_a <= 12'h5c3;
	endtask : t_freeze
	task automatic t_edges();
		logic [7:0] r;
		atp_host_model_inst.xfer({1'b0, atp_pkg::ADDR_PATTERN_LOW, 8'h5a}, 20, r);
		rd(atp_pkg::ADDR_PATTERN_LOW, r);
		chk("extra edges", {8'h00, r}, 16'h005a);
		atp_host_model_inst.xfer({1'b0, atp_pkg::ADDR_PATTERN_LOW, 8'h00}, 10, r);
		rd(atp_pkg::ADDR_PATTERN_LOW, r);
		chk("short frame", {8'h00, r}, 16'h005a);
	endtask : t_edges
	task automatic final_report();
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		srst <= 1'b1;
		ce <= 1'b1;
		sample_a <= 12'h5c3;
		sample_b <= 12'h9e1;
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		chk("high at reset", {8'h00, test_pattern_high_q}, 16'h0000);
		t_soft_reset();
		t_readback();
		t_force();
		t_freeze();
		t_edges();
		final_report();
	end
	// some two dozen frames of about 200 clocks each fit well inside this span
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		final_report();
	end
endmodule : tb_atp_regs
